// *** dv/ufb_peer.sv ***
`timescale 1ns/1ps
module ufb_peer (
  input  wire logic        clock,
  input  wire logic        txd,
  output logic             rxd,
  input  wire logic [15:0] bit_clks,
  input  wire logic [3:0]  nbits,
  input  wire logic        par_en
);
  logic [8:0] got_data;
  logic       got_par;
  int         gap;
  time        last;
  int         i;
  initial begin
    rxd = 1'b1;
    gap = 0;
    last = 0;
  end
  // sample each bit at its middle
  always begin
    @(negedge txd);
    gap = int'(($time - last) / 50);
    last = $time;
    got_data = 9'h000;
    repeat (bit_clks / 2) @(posedge clock);
    for (i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge clock);
      got_data[i] = txd;
    end
    if (par_en) begin
      repeat (bit_clks) @(posedge clock);
      got_par = txd;
    end
    repeat (bit_clks) @(posedge clock);
  end
  // one stop bit only, line idles high between frames
  task automatic send(input logic [8:0] d, input logic pb);
    logic [11:0] f;
    f = {1'b1, pb, d, 1'b0};
    for (int k = 0; k < 12; k++) begin
      @(posedge clock) rxd <= f[k];
      repeat (bit_clks - 1) @(posedge clock);
    end
  endtask : send
endmodule : ufb_peer

// *** dv/ufb_usart_frame_tb.sv ***
`timescale 1ns/1ps
module ufb_usart_frame_tb;
  typedef struct packed {
    logic [7:0] fr;
    logic [7:0] cb;
    logic [3:0] n;
    logic       pe;
    logic [8:0] d;
    logic       dbl;
    logic       dv;
  } ufb_case_t;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rv;
  logic        txd, rxd, sync_serial_clock, sync_serial_clock_oe, irq;
  logic        txd_p = 1'b1;
  logic        pol = 1'b0;
  logic [15:0] bclks = 16'h0010;
  logic [3:0]  nbits = 4'h8;
  logic        par_en = 1'b0;
  logic [8:0]  dm;
  ufb_case_t   t;
  int          num_errors = 0;
  int          total_checks = 0;
  ufb_case_t   cs [7] = '{
    '{8'h06, 8'h08, 4'h8, 1'b0, 9'h0A5, 1'b0, 1'b0},
    '{8'h28, 8'h08, 4'h5, 1'b1, 9'h013, 1'b0, 1'b0},
    '{8'h34, 8'h08, 4'h7, 1'b1, 9'h05A, 1'b0, 1'b0},
    '{8'h26, 8'h0D, 4'h9, 1'b1, 9'h13C, 1'b0, 1'b0},
    '{8'h12, 8'h08, 4'h6, 1'b0, 9'h02A, 1'b0, 1'b0},
    '{8'h06, 8'h08, 4'h8, 1'b0, 9'h0C3, 1'b1, 1'b0},
    '{8'h06, 8'h08, 4'h8, 1'b0, 9'h096, 1'b0, 1'b1}};
  always #25 clock = ~clock;
  ufb_usart_frame dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd, .rxd,
    .sync_serial_clock, .sync_serial_clock_oe, .irq);
  ufb_peer peer (.clock, .txd, .rxd, .bit_clks(bclks), .nbits, .par_en);
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic waitv(input int w);
    int   n;
    logic s;
    n = 0;
    s = 1'b0;
    while (s !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n > 50) begin
        chk("handshake", 1, 0);
        tally_and_finish();
      end
      case (w)
        0:       s = s_axi_awready;
        1:       s = s_axi_bvalid;
        2:       s = s_axi_arready;
        default: s = s_axi_rvalid;
      endcase
    end
  endtask : waitv
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    waitv(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    waitv(1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    waitv(2);
    s_axi_arvalid <= 1'b0;
    waitv(3);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic poll(input logic [7:0] a, input int b);
    for (int n = 0; n < 400; n++) begin
      rd(a);
      if (rv[b] === 1'b1) return;
    end
    chk("poll", 1, 0);
    tally_and_finish();
  endtask : poll
  // serial clock must launch data on the edge the polarity names
  always @(posedge clock) begin
    txd_p <= txd;
    if (sync_serial_clock_oe === 1'b1 && txd !== txd_p)
      chk("launch edge", {31'h0, ~pol}, {31'h0, sync_serial_clock});
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(8'h0C); chk("divisor low", 0, rv);
    rd(8'h08); chk("frame config", 0, rv);
    wr(8'h10, 8'hFF); rd(8'h10); chk("divisor high", 32'hF, rv);
    rd(8'h20); chk("unmapped resp", 2, {30'h0, rs});
    for (int c = 0; c < 7; c++) begin
      t = cs[c];
      nbits = t.n;
      par_en = t.pe;
      bclks = (t.dv ? 16'h0020 : 16'h0010) >> t.dbl;
      dm = t.d & ((9'h001 << t.n) - 9'h001);
      wr(8'h10, 8'h00);
      wr(8'h0C, {7'h00, t.dv});
      wr(8'h14, {6'h00, t.dbl, 1'b0});
      wr(8'h08, t.fr);
      wr(8'h04, t.cb);
      wr(8'h18, 8'h01);
      wr(8'h00, t.d[7:0]);
      poll(8'h14, 5);
      wr(8'h00, t.d[7:0]);
      poll(8'h18, 0);
      chk("tx data", {23'h0, dm}, {23'h0, peer.got_data});
      if (t.pe)
        chk("tx parity", {31'h0, ^dm ^ t.fr[4]}, {31'h0, peer.got_par});
      chk("frame length", (2 + t.n + t.pe + t.fr[3]) * bclks, peer.gap);
    end
    bclks = 16'h0010;
    wr(8'h0C, 8'h00);
    wr(8'h18, 8'h0F);
    wr(8'h08, 8'h2E);
    wr(8'h04, 8'h14);
    peer.send(9'h1C3, 1'b0);
    poll(8'h18, 1);
    rd(8'h04); chk("rx ninth", 1, {31'h0, rv[1]});
    rd(8'h14); chk("parity error", 32'h4, rv & 32'h14);
    rd(8'h00); chk("rx data", 32'hC3, rv);
    wr(8'h18, 8'h02);
    peer.send(9'h0A5, 1'b0);
    poll(8'h18, 1);
    rd(8'h14); chk("parity ok", 0, {31'h0, rv[2]});
    wr(8'h1C, 8'h00); chk("irq masked", 0, {31'h0, irq});
    wr(8'h1C, 8'h02); chk("irq raised", 1, {31'h0, irq});
    wr(8'h18, 8'h0F); chk("irq cleared", 0, {31'h0, irq});
    wr(8'h04, 8'h08);
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      wr(8'h18, 8'h01);
      wr(8'h08, {7'h23, pol});
      chk("clock enable", 1, {31'h0, sync_serial_clock_oe});
      wr(8'h00, 8'h69);
      poll(8'h18, 0);
    end
    wr(8'h08, 8'h06);
    chk("clock off", 0, {31'h0, sync_serial_clock_oe});
    tally_and_finish();
  end
endmodule : ufb_usart_frame_tb

// *** hw/ufb_baud.sv ***
`timescale 1ns/1ps
module ufb_baud (
  input wire logic      clock,
  input wire logic      rst,
  ufb_baud_if.prescaler bif
);
  ufb_pkg::ufb_div_t cnt_r;
  logic              tick_r;
  wire               at_zero = (cnt_r == 12'h000);

  assign bif.tick = tick_r;

  // (R17) count down, wrap
  // (R14) reload on low byte write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r  <= 12'h000;
      tick_r <= 1'b0;
    end else if (bif.reload) begin
      cnt_r  <= bif.divisor;
      tick_r <= 1'b0;
    end else if (at_zero) begin
      cnt_r  <= bif.divisor;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r - 12'h001;
      tick_r <= 1'b0;
    end
  end

  property p_reload;
    @(posedge clock) disable iff (rst)
    bif.reload |=> (cnt_r == $past(bif.divisor)) && !tick_r;
  endproperty
  a_reload: assert property (p_reload) // (R14)
    else $error("prescaler not reloaded");

  property p_period;
    @(posedge clock) disable iff (rst)
    (tick_r && !bif.reload && bif.divisor != 12'h000 &&
     $stable(bif.divisor)) |=> !tick_r;
  endproperty
  a_period: assert property (p_period) // (R17)
    else $error("tick too early");
endmodule : ufb_baud

// *** hw/ufb_usart_frame.sv ***
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ufb_map.svh"
module ufb_usart_frame (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic        txd,
  input  wire logic        rxd,
  output wire logic        sync_serial_clock,
  output wire logic        sync_serial_clock_oe,
  output wire logic        irq
);
  function automatic logic ufb_known(input logic [7:0] a);
    ufb_known = (a == `UFB_OFF_DATA) || (a == `UFB_OFF_CTRLB) ||
                (a == `UFB_OFF_FRAME) || (a == `UFB_OFF_DIVLO) ||
                (a == `UFB_OFF_DIVHI) || (a == `UFB_OFF_STATA) ||
                (a == `UFB_OFF_IRQST) || (a == `UFB_OFF_IRQMSK);
  endfunction : ufb_known

  function automatic logic [3:0] ufb_nbits(input logic [2:0] c);
    case (c)
      3'h0:    ufb_nbits = 4'h5;
      3'h1:    ufb_nbits = 4'h6;
      3'h2:    ufb_nbits = 4'h7;
      3'h7:    ufb_nbits = 4'h9;
      default: ufb_nbits = 4'h8;
    endcase
  endfunction : ufb_nbits

  function automatic logic ufb_parity(input logic [8:0] d,
                                      input logic [3:0] n,
                                      input logic       odd);
    logic [8:0] m;
    m = 9'h1FF >> (4'h9 - n);
    ufb_parity = (^(d & m)) ^ odd;
  endfunction : ufb_parity

  logic [6:0]  cfg_r;
  logic        rx_en_r, tx_en_r, szh_r, tx9_r, dbl_r;
  logic [3:0]  div_hi_r;
  logic [7:0]  div_lo_r;
  logic [3:0]  irq_st_r, irq_mask_r;
  logic        bvalid_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [7:0]  rdata_r;
  logic [8:0]  tx_buf_r, tx_sh_r, rx_data_r, rx_sh_r;
  logic        tx_full_r, txd_r, tx_par_r, sclk_r;
  logic [3:0]  tx_cnt_r, tx_os_r, rx_cnt_r, rx_os_r;
  logic        rx_valid_r, rx_perr_r, rx_ferr_r, rx_par_r;
  logic [2:0]  rx_s_r;
  logic        rx_lvl_r;
  ufb_pkg::ufb_state_t tx_st_r, rx_st_r;
  ufb_baud_if  bif ();

  // register bus decode
  wire       wr_go  = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  wire       wr_ok  = ufb_known(s_axi_awaddr);
  wire       wr_en  = wr_go & wr_ok & s_axi_wstrb[0];
  wire [7:0] wb     = s_axi_wdata[7:0];
  wire       wr_dat = wr_en & (s_axi_awaddr == `UFB_OFF_DATA);
  wire       wr_cb  = wr_en & (s_axi_awaddr == `UFB_OFF_CTRLB);
  wire       wr_ff  = wr_en & (s_axi_awaddr == `UFB_OFF_FRAME);
  wire       wr_lo  = wr_en & (s_axi_awaddr == `UFB_OFF_DIVLO);
  wire       wr_hi  = wr_en & (s_axi_awaddr == `UFB_OFF_DIVHI);
  wire       wr_sa  = wr_en & (s_axi_awaddr == `UFB_OFF_STATA);
  wire       wr_ist = wr_en & (s_axi_awaddr == `UFB_OFF_IRQST);
  wire       wr_msk = wr_en & (s_axi_awaddr == `UFB_OFF_IRQMSK);
  wire       rd_go  = s_axi_arvalid & ~rvalid_r;
  wire       rd_dat = rd_go & (s_axi_araddr == `UFB_OFF_DATA);

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = {24'h000000, rdata_r};

  // frame controls
  // (R3) mode select
  wire       sync   = cfg_r[`UFB_FF_SYNC];
  // (R4) only the upper parity bit enables
  wire       par_en = cfg_r[`UFB_FF_PARH];
  wire       par_od = cfg_r[`UFB_FF_PARO];
  wire       stop2  = cfg_r[`UFB_FF_STOP2];
  wire       pol    = cfg_r[`UFB_FF_POL];
  // (R9) size code decode
  wire [3:0] nbits  = ufb_nbits({szh_r, cfg_r[2:1]});
  // (R16) oversampling per bit
  wire [3:0] osr_m1 = (dbl_r & ~sync) ? `UFB_OSR_DBL : `UFB_OSR_NORM;
  wire       tick   = bif.tick;
  // (R11) edge roles follow polarity
  wire       tx_edg = sync & tick & (sclk_r == pol);
  wire       rx_edg = sync & tick & (sclk_r != pol);

  // (R12) divisor halves joined
  assign bif.divisor = {div_hi_r, div_lo_r};
  // (R14) low byte write reloads
  assign bif.reload  = wr_lo;

  ufb_baud u_baud (
    .clock (clock),
    .rst   (rst),
    .bif   (bif)
  );

  wire [7:0] stat_a = {rx_valid_r, 1'b0, ~tx_full_r, rx_ferr_r,
                       1'b0, rx_perr_r, dbl_r, 1'b0};
  wire [7:0] ctrl_b = {3'h0, rx_en_r, tx_en_r, szh_r, rx_data_r[8], tx9_r};
  // (R13) top nibble reads zero
  wire [7:0] rd_val =
    (s_axi_araddr == `UFB_OFF_DATA)   ? rx_data_r[7:0] :
    (s_axi_araddr == `UFB_OFF_CTRLB)  ? ctrl_b :
    (s_axi_araddr == `UFB_OFF_FRAME)  ? {1'b0, cfg_r} :
    (s_axi_araddr == `UFB_OFF_DIVLO)  ? div_lo_r :
    (s_axi_araddr == `UFB_OFF_DIVHI)  ? {4'h0, div_hi_r} :
    (s_axi_araddr == `UFB_OFF_STATA)  ? stat_a :
    (s_axi_araddr == `UFB_OFF_IRQST)  ? {4'h0, irq_st_r} :
    (s_axi_araddr == `UFB_OFF_IRQMSK) ? {4'h0, irq_mask_r} : 8'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `UFB_RESP_OK;
      rvalid_r <= 1'b0;
      rresp_r  <= `UFB_RESP_OK;
      rdata_r  <= `UFB_RST_BYTE;
    end else begin
      bvalid_r <= wr_go | (bvalid_r & ~s_axi_bready);
      if (wr_go)
        bresp_r <= wr_ok ? `UFB_RESP_OK : `UFB_RESP_ERR;
      rvalid_r <= rd_go | (rvalid_r & ~s_axi_rready);
      if (rd_go) begin
        rdata_r <= rd_val;
        rresp_r <= ufb_known(s_axi_araddr) ? `UFB_RESP_OK : `UFB_RESP_ERR;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_r    <= 7'h00;
      {rx_en_r, tx_en_r, szh_r, tx9_r, dbl_r} <= 5'h00;
      div_hi_r <= 4'h0;
      div_lo_r <= `UFB_RST_BYTE;
      irq_mask_r <= 4'h0;
    end else begin
      if (wr_ff)
        cfg_r <= wb[6:0];
      if (wr_cb) begin
        rx_en_r <= wb[`UFB_CB_RXEN];
        tx_en_r <= wb[`UFB_CB_TXEN];
        szh_r   <= wb[`UFB_CB_SZH];
        tx9_r   <= wb[`UFB_CB_TX9];
      end
      if (wr_sa)
        dbl_r <= wb[`UFB_SA_DBL];
      // (R13) upper nibble is not stored
      if (wr_hi)
        div_hi_r <= wb[3:0];
      if (wr_lo)
        div_lo_r <= wb;
      if (wr_msk)
        irq_mask_r <= wb[3:0];
    end
  end

  // synchronous clock: toggles per tick, held low in async mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      sclk_r <= 1'b0;
    else
      sclk_r <= sync & (sclk_r ^ tick);
  end
  assign sync_serial_clock    = sclk_r;
  assign sync_serial_clock_oe = sync;

  // transmitter
  wire tx_wrap = tick & (tx_os_r >= osr_m1);
  wire tx_bit  = sync ? tx_edg : tx_wrap;
  wire tx_go   = tx_full_r & tx_en_r;
  // (R7) second stop bit keeps the frame open one more bit
  wire tx_last = (tx_st_r == ufb_pkg::ST_STOP) &
                 ~(stop2 & (tx_cnt_r == 4'h0));
  wire tx_take = tx_bit & tx_go & ((tx_st_r == ufb_pkg::ST_IDLE) | tx_last);
  wire txc_ev  = tx_bit & tx_last & ~tx_go;

  // writes while the buffer is full are dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_full_r <= 1'b0;
      tx_buf_r  <= 9'h000;
      tx_os_r   <= 4'h0;
    end else begin
      tx_os_r <= tx_wrap ? 4'h0 : tx_os_r + {3'h0, tick};
      if (wr_dat & ~tx_full_r) begin
        tx_full_r <= 1'b1;
        // (R18) ninth bit joins the low byte
        tx_buf_r  <= {tx9_r, wb};
      end else if (tx_take)
        tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_st_r  <= ufb_pkg::ST_IDLE;
      txd_r    <= 1'b1;
      tx_sh_r  <= 9'h000;
      tx_cnt_r <= 4'h0;
      tx_par_r <= 1'b0;
    end else if (tx_take) begin
      tx_st_r  <= ufb_pkg::ST_START;
      txd_r    <= 1'b0;
      tx_sh_r  <= tx_buf_r;
      // (R5) parity computed at load
      tx_par_r <= ufb_parity(tx_buf_r, nbits, par_od);
    end else if (tx_bit) begin
      unique case (tx_st_r)
        ufb_pkg::ST_IDLE: txd_r <= 1'b1;
        ufb_pkg::ST_START: begin
          txd_r    <= tx_sh_r[0];
          tx_sh_r  <= tx_sh_r >> 1;
          tx_cnt_r <= 4'h1;
          tx_st_r  <= ufb_pkg::ST_DATA;
        end
        ufb_pkg::ST_DATA: begin
          // (R9) stop after nbits data bits
          if (tx_cnt_r == nbits) begin
            tx_cnt_r <= 4'h0;
            // (R5) parity bit inserted
            txd_r    <= par_en ? tx_par_r : 1'b1;
            tx_st_r  <= par_en ? ufb_pkg::ST_PAR : ufb_pkg::ST_STOP;
          end else begin
            txd_r    <= tx_sh_r[0];
            tx_sh_r  <= tx_sh_r >> 1;
            tx_cnt_r <= tx_cnt_r + 4'h1;
          end
        end
        ufb_pkg::ST_PAR: begin
          txd_r   <= 1'b1;
          tx_st_r <= ufb_pkg::ST_STOP;
        end
        ufb_pkg::ST_STOP: begin
          // (R7) one or two stop bits
          if (tx_last)
            tx_st_r <= ufb_pkg::ST_IDLE;
          else
            tx_cnt_r <= 4'h1;
        end
      endcase
    end
  end
  assign txd = txd_r;

  // receiver: three flops, level moves once the last two agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_s_r   <= 3'h7;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s_r <= {rx_s_r[1:0], rxd};
      if (rx_s_r[1] == rx_s_r[2])
        rx_lvl_r <= rx_s_r[2];
    end
  end

  wire       rx_half = tick & (rx_st_r == ufb_pkg::ST_START) &
                       (rx_os_r == (osr_m1 >> 1));
  wire       rx_smp  = sync ? rx_edg : (tick & (rx_os_r >= osr_m1));
  // (R8) one stop bit checked whatever stop select says
  wire       rx_done = rx_en_r & rx_smp & (rx_st_r == ufb_pkg::ST_STOP);
  // (R18) realign so the ninth bit lands in bit 8
  wire [8:0] rx_word = rx_sh_r >> (4'h9 - nbits);
  // (R6) compare received parity with computed
  wire       pe_ev   = rx_done & par_en &
                       (rx_par_r != ufb_parity(rx_word, nbits, par_od));
  wire       fe_ev   = rx_done & ~rx_lvl_r;
  wire       rx_idle = (rx_st_r == ufb_pkg::ST_IDLE);

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      rx_os_r <= 4'h0;
    else if (rx_idle | rx_half | rx_smp)
      rx_os_r <= 4'h0;
    else
      rx_os_r <= rx_os_r + {3'h0, tick};
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_st_r  <= ufb_pkg::ST_IDLE;
      rx_sh_r  <= 9'h000;
      rx_cnt_r <= 4'h0;
      rx_par_r <= 1'b0;
    end else if (!rx_en_r)
      rx_st_r <= ufb_pkg::ST_IDLE;
    else begin
      unique case (rx_st_r)
        ufb_pkg::ST_IDLE: begin
          rx_cnt_r <= 4'h0;
          if (!rx_lvl_r && (!sync || rx_edg))
            rx_st_r <= sync ? ufb_pkg::ST_DATA : ufb_pkg::ST_START;
        end
        ufb_pkg::ST_START: begin
          // false start bits are dropped at mid bit
          if (rx_half)
            rx_st_r <= rx_lvl_r ? ufb_pkg::ST_IDLE : ufb_pkg::ST_DATA;
        end
        ufb_pkg::ST_DATA: begin
          if (rx_smp) begin
            rx_sh_r  <= {rx_lvl_r, rx_sh_r[8:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == nbits - 4'h1)
              rx_st_r <= par_en ? ufb_pkg::ST_PAR : ufb_pkg::ST_STOP;
          end
        end
        ufb_pkg::ST_PAR: begin
          if (rx_smp) begin
            rx_par_r <= rx_lvl_r;
            rx_st_r  <= ufb_pkg::ST_STOP;
          end
        end
        ufb_pkg::ST_STOP: begin
          if (rx_smp)
            rx_st_r <= ufb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // a new frame overwrites unread data; set beats the read clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_valid_r <= 1'b0;
      rx_data_r  <= 9'h000;
      rx_perr_r  <= 1'b0;
      rx_ferr_r  <= 1'b0;
    end else if (!rx_en_r) begin
      rx_valid_r <= 1'b0;
      rx_perr_r  <= 1'b0;
      rx_ferr_r  <= 1'b0;
    end else if (rx_done) begin
      rx_valid_r <= 1'b1;
      // (R18) ninth bit stored for reading
      rx_data_r  <= rx_word;
      // (R6) parity error flag
      rx_perr_r  <= pe_ev;
      rx_ferr_r  <= fe_ev;
    end else if (rd_dat)
      rx_valid_r <= 1'b0;
  end

  // interrupt status: sticky, write one to clear, set wins
  wire [3:0] ev = {fe_ev, pe_ev, rx_done, txc_ev};
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      irq_st_r <= 4'h0;
    else
      irq_st_r <= (irq_st_r & ~(wr_ist ? wb[3:0] : 4'h0)) | ev;
  end
  assign irq = |(irq_st_r & irq_mask_r);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_mode;
    !sync_serial_clock_oe |=> !sync_serial_clock;
  endproperty
  a_mode: assert property (p_mode) // (R3)
    else $error("serial clock runs in asynchronous mode");

  property p_par_off;
    !par_en |-> tx_st_r != ufb_pkg::ST_PAR;
  endproperty
  a_par_off: assert property (p_par_off) // (R4)
    else $error("parity bit sent while disabled");

  property p_tx_par;
    (tx_bit && tx_st_r == ufb_pkg::ST_DATA && tx_cnt_r == nbits && par_en)
      |=> txd == tx_par_r && tx_st_r == ufb_pkg::ST_PAR;
  endproperty
  a_tx_par: assert property (p_tx_par) // (R5)
    else $error("parity bit missing");

  property p_perr;
    (rx_done && par_en &&
     rx_par_r != ufb_parity(rx_word, nbits, par_od)) |=> rx_perr_r;
  endproperty
  a_perr: assert property (p_perr) // (R6)
    else $error("parity error not flagged");

  property p_stop2;
    (tx_bit && !tx_take && tx_st_r == ufb_pkg::ST_STOP && stop2 &&
     tx_cnt_r == 4'h0) |=> tx_st_r == ufb_pkg::ST_STOP && txd;
  endproperty
  a_stop2: assert property (p_stop2) // (R7)
    else $error("second stop bit missing");

  property p_nbits;
    (tx_bit && !tx_take && tx_st_r == ufb_pkg::ST_DATA &&
     tx_cnt_r == nbits) |=> tx_st_r != ufb_pkg::ST_DATA;
  endproperty
  a_nbits: assert property (p_nbits) // (R9)
    else $error("wrong data bit count");

  property p_pol;
    tx_edg |-> sync_serial_clock == pol ##1
               sync_serial_clock != $past(pol);
  endproperty
  a_pol: assert property (p_pol) // (R11)
    else $error("transmit edge on wrong clock edge");

  property p_hi_zero;
    (rd_go && s_axi_araddr == `UFB_OFF_DIVHI) |=> rdata_r[7:4] == 4'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) // (R13)
    else $error("reserved divisor bits not zero");

  property p_dbl;
    (!sync && dbl_r && tick && tx_os_r == 4'h7) |=> tx_os_r == 4'h0;
  endproperty
  a_dbl: assert property (p_dbl) // (R16)
    else $error("double speed divisor not eight");

  c_tx_par: cover property (tx_st_r == ufb_pkg::ST_PAR ##1
                            tx_st_r == ufb_pkg::ST_STOP);
  c_rx_nine: cover property (rx_done && nbits == 4'h9);
  c_irq: cover property ($rose(irq));
endmodule : ufb_usart_frame

// *** pkg/ufb_baud_if.sv ***
`timescale 1ns/1ps
interface ufb_baud_if;
  ufb_pkg::ufb_div_t divisor;
  logic              reload;
  logic              tick;
  modport ctrl (output divisor, output reload, input tick);
  modport prescaler (input divisor, input reload, output tick);
endinterface : ufb_baud_if

// *** pkg/ufb_map.svh ***
`ifndef UFB_MAP_SVH
`define UFB_MAP_SVH
// Summary of operation
// (R1) Host reads the received ninth bit before the low data byte.
// (R2) Host writes the transmit ninth bit before the low data byte.
// (R3) Mode bit: 0 asynchronous, 1 synchronous operation.
// (R4) Parity field: 00 off, 01 reserved, 10 even, 11 odd.
// (R5) Transmitter computes parity over data bits and sends it.
// (R6) Receiver checks parity and sets the parity error flag on mismatch.
// (R7) Transmitter sends one stop bit, or two when stop select is set.
// (R8) Receiver ignores the stop select setting.
// (R9) Size code sets 5, 6, 7, 8 or 9 data bits both ways.
// (R10) Software keeps clock polarity zero in asynchronous mode.
// (R11) Polarity 0: send on rising, sample on falling; 1 swaps.
// (R12) Baud divisor is 12 bits: high nibble and low byte.
// (R13) Divisor high byte top four bits are written and read as zero.
// (R14) Writing the divisor low byte reloads the prescaler at once.
// (R15) Software changes the divisor only while no frame is moving.
// (R16) Double speed cuts the asynchronous per-bit divisor from 16 to 8.
// (R17) Prescaler counts down, one tick every divisor plus one clocks.
// (R18) Nine-bit frames send and store the ninth bit after eight low bits.
`define UFB_OFF_DATA   8'h00
`define UFB_OFF_CTRLB  8'h04
`define UFB_OFF_FRAME  8'h08
`define UFB_OFF_DIVLO  8'h0C
`define UFB_OFF_DIVHI  8'h10
`define UFB_OFF_STATA  8'h14
`define UFB_OFF_IRQST  8'h18
`define UFB_OFF_IRQMSK 8'h1C
`define UFB_FF_SYNC    6
`define UFB_FF_PARH    5
`define UFB_FF_PARO    4
`define UFB_FF_STOP2   3
`define UFB_FF_POL     0
`define UFB_CB_RXEN    4
`define UFB_CB_TXEN    3
`define UFB_CB_SZH     2
`define UFB_CB_TX9     0
`define UFB_SA_DBL     1
`define UFB_OSR_NORM   4'hF
`define UFB_OSR_DBL    4'h7
`define UFB_RST_BYTE   8'h00
`define UFB_RESP_OK    2'h0
`define UFB_RESP_ERR   2'h2
`endif

// *** pkg/ufb_pkg.sv ***
package ufb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } ufb_state_t;
  typedef logic [11:0] ufb_div_t;
endpackage : ufb_pkg
